// ===== rtl/cfgst_top.sv
// configuration status register and word ordering over scan and byte ports
// assumes an async-read frame store outside, addressed by mem_frame_q/mem_word_q
`timescale 1ns/10ps
module cfgst_top
  import cfgst_pkg::*;
#(
  parameter int FRAME_WORDS = RB_FRAME_WORDS
) (
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  input  wire logic                  done_pin,
  input  wire logic                  init_level,
  input  wire logic [2:0]            mode_select_pins,
  input  wire logic                  global_high_hold_n,
  input  wire logic                  global_set_reset_n,
  input  wire logic                  global_write_enable_n,
  input  wire logic                  global_tristate_release,
  input  wire logic                  legacy_input_error,
  input  wire logic [3:0]            dll_lock,
  input  wire logic                  crc_error_event,
  input  wire logic                  crc_error_clear,
  input  wire logic                  scan_capture,
  input  wire logic                  scan_shift,
  input  wire logic                  scan_tdi,
  output logic                       scan_tdo_q,
  input  wire logic                  byte_read_sel,
  input  wire logic                  byte_rd_strobe,
  input  wire logic                  byte_wr_strobe,
  input  wire logic [7:0]            byte_data_in,
  output logic      [7:0]            byte_data_out_q,
  output logic                       byte_data_oe_n_q,
  input  wire logic                  rb_start,
  input  wire logic [RB_CNT_W-1:0]   rb_num_frames,
  input  wire logic [CFG_WORD_W-1:0] frame_data,
  output logic      [RB_CNT_W-1:0]   mem_frame_q,
  output logic      [RB_CNT_W-1:0]   mem_word_q,
  output logic      [CFG_WORD_W-1:0] status_q,
  output logic      [CFG_WORD_W-1:0] wr_word_q,
  output logic                       wr_word_valid_q
);

  logic [1:0]            rst_sync_q;
  logic                  rst_n;
  logic                  rb_active;
  logic                  rb_pad;
  logic                  rb_advance;
  logic [CFG_WORD_W-1:0] src_word;
  logic [CFG_WORD_W-1:0] tx_q;
  logic [CFG_WORD_W-1:0] sh_q;
  logic [SCAN_CNT_W-1:0] sc_cnt_q;
  logic [BYTE_CNT_W-1:0] rd_cnt_q;
  logic [BYTE_CNT_W-1:0] wr_cnt_q;
  logic [23:0]           wr_buf_q;
  logic                  scan_word_done;
  logic                  byte_word_done;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // one register serves both ports; reserved bits stay zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q                                <= STATUS_RESET;
      status_q[ST_DONE_BIT]                   <= done_pin;
      status_q[ST_INIT_BIT]                   <= init_level;
      status_q[ST_MODE_LSB +: 3]              <= mode_select_pins;
      status_q[ST_HIGH_BIT]                   <= global_high_hold_n;
      status_q[ST_GSR_BIT]                    <= global_set_reset_n;
      status_q[ST_GWE_BIT]                    <= global_write_enable_n;
      status_q[ST_GTS_BIT]                    <= global_tristate_release;
      status_q[ST_INERR_BIT]                  <= legacy_input_error;
      status_q[ST_LOCK_LSB +: 4]              <= dll_lock;
      // a new error in the clearing cycle survives the clear
      status_q[ST_CRC_BIT]                    <= crc_error_event | (status_q[ST_CRC_BIT] & ~crc_error_clear);
    end
  end

  cfgst_rb_seq #(
    .FRAME_WORDS (FRAME_WORDS),
    .CNT_W       (RB_CNT_W)
  ) u_seq (
    .clk        (sys_clk),
    .rst_n      (rst_n),
    .start      (rb_start),
    .num_frames (rb_num_frames),
    .advance    (rb_advance),
    .active     (rb_active),
    .pad        (rb_pad),
    .frame_q    (mem_frame_q),
    .word_q     (mem_word_q)
  );

  // status is only readable while no readback runs; pad words read as zero
  assign src_word       = !rb_active ? status_q : (rb_pad ? '0 : frame_data);
  assign scan_word_done = scan_shift && !scan_capture && (sc_cnt_q == SCAN_LAST_BIT);
  assign byte_word_done = byte_rd_strobe && (rd_cnt_q == BYTE_LAST);
  assign rb_advance     = rb_active && (scan_word_done || byte_word_done);

  // scan port: one register shifts out the read word and in the written word
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q       <= '0;
      sc_cnt_q   <= '0;
      scan_tdo_q <= 1'b0;
    end else if (scan_capture) begin
      sh_q       <= src_word;
      sc_cnt_q   <= '0;
      scan_tdo_q <= src_word[CFG_WORD_W-1];
    end else if (scan_shift) begin
      sh_q       <= {sh_q[CFG_WORD_W-2:0], scan_tdi};
      sc_cnt_q   <= sc_cnt_q + 1'b1;
      scan_tdo_q <= sh_q[CFG_WORD_W-2];
    end
  end

  // byte port read side: word latched at byte 0 so later bytes stay coherent
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_q            <= '0;
      rd_cnt_q        <= '0;
      byte_data_out_q <= 8'h00;
    end else if (byte_rd_strobe) begin
      rd_cnt_q <= rd_cnt_q + 1'b1;
      if (rd_cnt_q == '0) begin
        tx_q            <= src_word;
        byte_data_out_q <= cfgst_rev8(cfgst_word_byte(src_word, 2'h0));
      end else begin
        byte_data_out_q <= cfgst_rev8(cfgst_word_byte(tx_q, rd_cnt_q));
      end
    end
  end

  // drivers on only while the host reads
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_data_oe_n_q <= 1'b1;
    end else begin
      byte_data_oe_n_q <= ~byte_read_sel;
    end
  end

  // write side: bytes or bits build one word, handed on as a pulse
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_buf_q        <= '0;
      wr_cnt_q        <= '0;
      wr_word_q       <= '0;
      wr_word_valid_q <= 1'b0;
    end else begin
      wr_word_valid_q <= 1'b0;
      if (byte_wr_strobe) begin
        wr_cnt_q <= wr_cnt_q + 1'b1;
        wr_buf_q <= {wr_buf_q[15:0], cfgst_rev8(byte_data_in)};
        if (wr_cnt_q == BYTE_LAST) begin
          wr_word_q       <= {wr_buf_q, cfgst_rev8(byte_data_in)};
          wr_word_valid_q <= 1'b1;
        end
      end else if (scan_word_done) begin
        wr_word_q       <= {sh_q[CFG_WORD_W-2:0], scan_tdi};
        wr_word_valid_q <= 1'b1;
      end
    end
  end

  reserved_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    status_q[CFG_WORD_W-1:ST_RSVD_LSB] == '0)
    else $error("reserved status bits not zero");

  // the edge that lifts the internal reset still loads the reset value, so mirroring starts one edge later
  pin_fields_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rst_n |=> status_q[ST_DONE_BIT:ST_MODE_LSB] == $past({done_pin, init_level, mode_select_pins}))
    else $error("done, init or mode bits stale");

  globals_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rst_n |=> status_q[ST_HIGH_BIT:ST_GTS_BIT] == $past({global_high_hold_n, global_set_reset_n,
                                                   global_write_enable_n, global_tristate_release}))
    else $error("global control bits stale");

  lock_bits_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rst_n |=> status_q[ST_LOCK_LSB +: 4] == $past(dll_lock))
    else $error("lock bits do not follow the loops");

  crc_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    crc_error_event ##1 !crc_error_event [*2] |-> status_q[ST_CRC_BIT] || $past(crc_error_clear))
    else $error("crc error flag lost");

  in_error_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    legacy_input_error |=> status_q[ST_INERR_BIT])
    else $error("input error not reported");

  scan_msb_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scan_capture ##1 (scan_shift && !scan_capture) |=> scan_tdo_q == $past(src_word[CFG_WORD_W-2], 2))
    else $error("scan word not shifted msb first");

  byte_pins_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (byte_rd_strobe && rd_cnt_q == '0) |=>
      (byte_data_out_q[0] == $past(src_word[31]) && byte_data_out_q[7] == $past(src_word[24])))
    else $error("byte lanes in the wrong pin order");

  pad_read_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (byte_rd_strobe && rd_cnt_q == '0 && rb_pad) |=> byte_data_out_q == 8'h00)
    else $error("pad word read as nonzero");

  byte_word_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (byte_wr_strobe && wr_cnt_q == '0) ##1 byte_wr_strobe [*3] |=>
      (wr_word_valid_q &&
       wr_word_q[31:24] == cfgst_rev8($past(byte_data_in, 4)) &&
       wr_word_q[23:16] == cfgst_rev8($past(byte_data_in, 3)) &&
       wr_word_q[15:8] == cfgst_rev8($past(byte_data_in, 2)) &&
       wr_word_q[7:0] == cfgst_rev8($past(byte_data_in))))
    else $error("written word assembled in the wrong byte order");

  scan_word_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    scan_word_done ##1 wr_word_valid_q);

  byte_word_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    byte_word_done && rb_active);

  crc_flag_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    crc_error_event && crc_error_clear ##1 status_q[ST_CRC_BIT]);

endmodule

// ===== rtl/cfgst_pkg.sv
// constants, types and helpers for the configuration status and word-order block
// assumes one 10 MHz clock; every pin and strobe is synchronous to it
// How it works
// - status register samples live signals, read by both ports
// - bits 14..10 show done, init, mode pins
// - bit 9 reads 0 while high-hold asserted
// - bit 8 reads 0 while set/reset holds
// - bit 7 reads 1 while writes disabled
// - bit 6 reads 0 while I/O tristated
// - bits 4..1 mirror the four lock outputs
// - bit 0 sticky CRC error, bit 5 input error
// - traffic over scan port or byte port
// - frames and words go in ascending order
// - scan port shifts each word MSB first
// - byte port sends byte 0 first, then 1..3
// - each byte's MSB sits on pin 0
// - each byte's LSB sits on pin 7
// - readback pads each frame, then longer pad frame
package cfgst_pkg;

  localparam int          CFG_WORD_W      = 32;
  localparam int          CFG_BYTE_W      = 8;
  localparam int          RB_FRAME_WORDS  = 11;
  localparam int          RB_CNT_W        = 8;
  localparam int          SCAN_CNT_W      = 5;
  localparam int          BYTE_CNT_W      = 2;

  localparam logic [31:0] STATUS_RESET    = 32'h0000_0000;
  localparam int          ST_RSVD_LSB     = 15;
  localparam int          ST_DONE_BIT     = 14;
  localparam int          ST_INIT_BIT     = 13;
  localparam int          ST_MODE_LSB     = 10;
  localparam int          ST_HIGH_BIT     = 9;
  localparam int          ST_GSR_BIT      = 8;
  localparam int          ST_GWE_BIT      = 7;
  localparam int          ST_GTS_BIT      = 6;
  localparam int          ST_INERR_BIT    = 5;
  localparam int          ST_LOCK_LSB     = 1;
  localparam int          ST_CRC_BIT      = 0;

  localparam logic [4:0]  SCAN_LAST_BIT   = 5'h1F;
  localparam logic [1:0]  BYTE_LAST       = 2'h3;

  typedef enum logic [1:0] {RB_IDLE, RB_DATA, RB_PADW, RB_PADF} cfgst_rb_state_t;

  // pin 0 carries the byte's msb, so pins are the byte reversed
  function automatic logic [7:0] cfgst_rev8(input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7-i];
    end
    return r;
  endfunction

  // byte k of a word, byte 0 being the most significant
  function automatic logic [7:0] cfgst_word_byte(input logic [31:0] w, input logic [1:0] k);
    return w[{~k, 3'b000} +: 8];
  endfunction

endpackage

// ===== rtl/cfgst_rb_seq.sv
// readback sequencer: walks data frames, pad words and the closing pad frame
// assumes advance pulses once per word fully handed to the host
`timescale 1ns/10ps
module cfgst_rb_seq
  import cfgst_pkg::*;
#(
  parameter int FRAME_WORDS = RB_FRAME_WORDS,
  parameter int CNT_W       = RB_CNT_W
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] num_frames,
  input  wire logic             advance,
  output logic                  active,
  output logic                  pad,
  output logic      [CNT_W-1:0] frame_q,
  output logic      [CNT_W-1:0] word_q
);

  localparam logic [CNT_W-1:0] LAST_DATA = CNT_W'(FRAME_WORDS - 1);
  localparam logic [CNT_W-1:0] PAD_LAST  = CNT_W'(FRAME_WORDS);

  if (FRAME_WORDS < 1 || FRAME_WORDS + 1 >= (1 << CNT_W)) begin : g_chk
    $error("frame length does not fit the word counter");
  end

  cfgst_rb_state_t  state_q;
  logic [CNT_W-1:0] last_frame_q;

  assign active = (state_q != RB_IDLE);
  assign pad    = (state_q == RB_PADW) || (state_q == RB_PADF);

  // num_frames is latched so the host may change it mid-readback
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= RB_IDLE;
      frame_q      <= '0;
      word_q       <= '0;
      last_frame_q <= '0;
    end else begin
      unique case (state_q)
        RB_IDLE: if (start) begin
          frame_q      <= '0;
          word_q       <= '0;
          last_frame_q <= num_frames - 1'b1;
          state_q      <= (num_frames == '0) ? RB_PADF : RB_DATA;
        end
        RB_DATA: if (advance) begin
          if (word_q == LAST_DATA) begin
            word_q  <= '0;
            state_q <= RB_PADW;
          end else begin
            word_q  <= word_q + 1'b1;
          end
        end
        RB_PADW: if (advance) begin
          if (frame_q == last_frame_q) begin
            state_q <= RB_PADF;
          end else begin
            frame_q <= frame_q + 1'b1;
            state_q <= RB_DATA;
          end
        end
        RB_PADF: if (advance) begin
          if (word_q == PAD_LAST) begin
            word_q  <= '0;
            state_q <= RB_IDLE;
          end else begin
            word_q  <= word_q + 1'b1;
          end
        end
      endcase
    end
  end

  pad_after_frame_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == RB_DATA && advance && word_q == LAST_DATA) |=> (state_q == RB_PADW))
    else $error("no pad word after a data frame");

  pad_frame_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == RB_PADF && advance && word_q == PAD_LAST) |=> (state_q == RB_IDLE && word_q == '0))
    else $error("pad frame has the wrong length");

  word_ascend_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == RB_DATA && advance && word_q != LAST_DATA) |=> (word_q == $past(word_q) + 1'b1))
    else $error("readback words not ascending");

  rb_done_c: cover property (@(posedge clk) disable iff (!rst_n)
    (state_q == RB_PADF) ##1 (state_q == RB_IDLE));

endmodule

// ===== tb/cfgst_frame_store.sv
// frame store model on the readback side: one word per frame/word position
// assumes the block reads it asynchronously and needs the data in the same cycle
`timescale 1ns/10ps
module cfgst_frame_store
  import cfgst_pkg::*;
(
  input  wire logic [RB_CNT_W-1:0]   frame_idx,
  input  wire logic [RB_CNT_W-1:0]   word_idx,
  output logic      [CFG_WORD_W-1:0] data
);
  // every position holds a defined word, so a misplaced read shows as a wrong value, never a hole
  assign data = {16'hC0DE, frame_idx, word_idx};
endmodule

// ===== tb/cfgst_top_bench.sv
// self-checking bench for the status register and word ordering block
// assumes a 10 MHz clock; inputs change on the falling edge, outputs are sampled there
`timescale 1ns/10ps
module cfgst_top_bench;
  import cfgst_pkg::*;
  localparam int FW = 2;

  logic                  sys_clk = 1'b0;
  logic                  reset_n, done_pin, init_level, global_high_hold_n, global_set_reset_n;
  logic                  global_write_enable_n, global_tristate_release, legacy_input_error;
  logic                  crc_error_event, crc_error_clear, scan_capture, scan_shift, scan_tdi;
  logic                  byte_read_sel, byte_rd_strobe, byte_wr_strobe, rb_start;
  logic [2:0]            mode_select_pins;
  logic [3:0]            dll_lock;
  logic [7:0]            byte_data_in, byte_data_out_q, rb_num_frames, mem_frame_q, mem_word_q;
  logic [31:0]           frame_data, status_q, wr_word_q, st_exp, r;
  logic                  scan_tdo_q, byte_data_oe_n_q, wr_word_valid_q;
  logic [14:0]           pats [3] = '{15'h7FFE, 15'h2AAA, 15'h5554};
  int                    n_mismatch = 0;
  int                    cmp_count = 0;
  int                    cyc = 0;

  always #50 sys_clk = ~sys_clk;

  cfgst_top #(.FRAME_WORDS(FW)) i_cfgst_top (
    .sys_clk(sys_clk), .reset_n(reset_n), .done_pin(done_pin), .init_level(init_level),
    .mode_select_pins(mode_select_pins), .global_high_hold_n(global_high_hold_n),
    .global_set_reset_n(global_set_reset_n), .global_write_enable_n(global_write_enable_n),
    .global_tristate_release(global_tristate_release), .legacy_input_error(legacy_input_error),
    .dll_lock(dll_lock), .crc_error_event(crc_error_event), .crc_error_clear(crc_error_clear),
    .scan_capture(scan_capture), .scan_shift(scan_shift), .scan_tdi(scan_tdi), .scan_tdo_q(scan_tdo_q),
    .byte_read_sel(byte_read_sel), .byte_rd_strobe(byte_rd_strobe), .byte_wr_strobe(byte_wr_strobe),
    .byte_data_in(byte_data_in), .byte_data_out_q(byte_data_out_q), .byte_data_oe_n_q(byte_data_oe_n_q),
    .rb_start(rb_start), .rb_num_frames(rb_num_frames), .frame_data(frame_data),
    .mem_frame_q(mem_frame_q), .mem_word_q(mem_word_q), .status_q(status_q),
    .wr_word_q(wr_word_q), .wr_word_valid_q(wr_word_valid_q)
  );

  cfgst_frame_store i_cfgst_frame_store (.frame_idx(mem_frame_q), .word_idx(mem_word_q), .data(frame_data));

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // pin 0 holds the byte's msb, so the lane is the byte mirrored
  function automatic logic [7:0] flip(input logic [7:0] b);
    logic [7:0] o;
    for (int i = 0; i < 8; i++) begin
      o[i] = b[7-i];
    end
    return o;
  endfunction

  task automatic set_st(input logic [14:0] v);
    {done_pin, init_level, mode_select_pins, global_high_hold_n, global_set_reset_n} = v[14:8];
    {global_write_enable_n, global_tristate_release, legacy_input_error, dll_lock} = v[7:1];
    st_exp = {17'h00000, v[14:1], 1'b0};
    @(negedge sys_clk);
  endtask

  // ends with a spare cycle so the strobe is never lowered and raised in one time step
  task automatic rd_word(output logic [31:0] w);
    w = 32'h0000_0000;
    byte_read_sel = 1'b1;
    byte_rd_strobe = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(negedge sys_clk);
      w = {w[23:0], flip(byte_data_out_q)};
    end
    byte_rd_strobe = 1'b0;
    byte_read_sel = 1'b0;
    check({31'h0, byte_data_oe_n_q}, 32'h0000_0000);
    @(negedge sys_clk);
  endtask

  task automatic wr_word(input logic [31:0] w);
    for (int i = 0; i < 4; i++) begin
      byte_data_in = flip(w[31-8*i -: 8]);
      byte_wr_strobe = 1'b1;
      @(negedge sys_clk);
    end
    byte_wr_strobe = 1'b0;
    check({31'h0, wr_word_valid_q}, 32'h0000_0001);
    check(wr_word_q, w);
    @(negedge sys_clk);
    check({31'h0, wr_word_valid_q}, 32'h0000_0000);
  endtask

  task automatic scan_word(input logic [31:0] wi, output logic [31:0] wo);
    scan_capture = 1'b1;
    @(negedge sys_clk);
    scan_capture = 1'b0;
    scan_shift = 1'b1;
    for (int i = 0; i < 32; i++) begin
      wo[31-i] = scan_tdo_q;
      scan_tdi = wi[31-i];
      @(negedge sys_clk);
    end
    scan_shift = 1'b0;
    @(negedge sys_clk);
    check(wr_word_q, wi);
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    {reset_n, crc_error_event, crc_error_clear, scan_capture, scan_shift, scan_tdi} = 6'h00;
    {byte_read_sel, byte_rd_strobe, byte_wr_strobe, rb_start} = 4'h0;
    byte_data_in = 8'h00;
    rb_num_frames = 8'h00;
    {done_pin, init_level, mode_select_pins, global_high_hold_n, global_set_reset_n} = 7'h00;
    {global_write_enable_n, global_tristate_release, legacy_input_error, dll_lock} = 7'h00;
    repeat (4) @(negedge sys_clk);
    check(status_q, 32'h0000_0000);
    check({31'h0, byte_data_oe_n_q}, 32'h0000_0001);
    reset_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    foreach (pats[p]) begin
      set_st(pats[p]);
      check(status_q, st_exp);
      rd_word(r);
      check(r, st_exp);
      scan_word(~st_exp, r);
      check(r, st_exp);
    end
    check({31'h0, byte_data_oe_n_q}, 32'h0000_0001);
    crc_error_event = 1'b1;
    @(negedge sys_clk);
    crc_error_event = 1'b0;
    repeat (3) @(negedge sys_clk);
    check(status_q, st_exp | 32'h0000_0001);
    {crc_error_event, crc_error_clear} = 2'h3;
    @(negedge sys_clk);
    check(status_q, st_exp | 32'h0000_0001);
    crc_error_event = 1'b0;
    @(negedge sys_clk);
    crc_error_clear = 1'b0;
    check(status_q, st_exp);
    wr_word(32'h8137_5AC3);
    wr_word(32'hF00F_1E2D);
    rb_num_frames = 8'h02;
    rb_start = 1'b1;
    @(negedge sys_clk);
    rb_start = 1'b0;
    for (int f = 0; f < 2; f++) begin
      for (int k = 0; k <= FW; k++) begin
        rd_word(r);
        check(r, (k == FW) ? 32'h0000_0000 : {16'hC0DE, 8'(f), 8'(k)});
      end
    end
    for (int k = 0; k <= FW; k++) begin
      rd_word(r);
      check(r, 32'h0000_0000);
    end
    rd_word(r);
    check(r, st_exp);
    rb_num_frames = 8'h00;
    rb_start = 1'b1;
    @(negedge sys_clk);
    rb_start = 1'b0;
    for (int k = 0; k <= FW; k++) begin
      scan_word(32'h1234_5678, r);
      check(r, 32'h0000_0000);
    end
    scan_word(32'h0000_0000, r);
    check(r, st_exp);
    finish_test();
  end
endmodule
